// *** sim/fwp_core_assertions.sv ***
`timescale 1ns/100ps
module fwp_core_assertions
	import fwp_pkg::*;
#(
	parameter int POWERUP_DELAY_CYCLES = POWERUP_CYCLES
)
(
	// Clock and reset
	input  wire logic              core_clk_in,
	input  wire logic              sys_rst_in,
	// Inputs watched
	input  wire logic              cmd_end_in,
	input  wire logic [7:0]        cmd_opcode_in,
	input  wire logic [5:0]        cmd_bit_count_in,
	input  wire logic              op_done_in,
	input  wire logic              write_protect_pin_n_in,
	input  wire logic              status_protect_mode_hi_in,
	input  wire logic              status_protect_mode_lo_in,
	input  wire logic              dummy_cycle_select_in,
	input  wire logic [7:0]        read_opcode_in,
	// Outputs watched
	input  wire logic              start_array_op_out,
	input  wire logic              start_chip_erase_out,
	input  wire logic              start_status_write_out,
	input  wire logic              cmd_rejected_out,
	input  wire logic              write_enable_latch_out,
	input  wire logic              deep_power_down_out,
	input  wire logic              ready_out,
	input  wire logic [3:0]        dummy_cycles_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	logic wr;
	logic none;
	int   cnt;
	assign wr = cmd_opcode_in inside {OP_PAGE_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE,
		OP_CHIP_ERASE, OP_WRITE_STATUS};
	assign none = !(start_array_op_out || start_chip_erase_out || start_status_write_out);
	// Edges since reset, so the lockout length can be pinned down.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in)
			cnt <= 0;
		else if (cnt < 1000000)
			cnt <= cnt + 1;
	end
	sequence write_ended;
		cmd_end_in && wr;
	endsequence
	sequence other_ended;
		cmd_end_in && cmd_opcode_in != OP_RELEASE_PD;
	endsequence
	byte_length_a: assert property (write_ended ##0 cmd_bit_count_in[2:0] != 3'h0 |=>
		cmd_rejected_out) else $error("unaligned write command not rejected");
	lockout_reject_a: assert property (cmd_end_in ##1 !ready_out |-> cmd_rejected_out)
		else $error("command taken during lockout");
	ready_rise_a: assert property ($rose(ready_out) |-> cnt >= POWERUP_DELAY_CYCLES &&
		cnt <= POWERUP_DELAY_CYCLES + 2) else $error("ready rose at wrong time");
	wel_power_a: assert property ($fell(sys_rst_in) |-> !write_enable_latch_out &&
		!ready_out) else $error("latch or ready set after reset");
	latch_needed_a: assert property (write_ended ##1 !write_enable_latch_out |-> none)
		else $error("write started without latch");
	done_clears_a: assert property (op_done_in && !(cmd_end_in &&
		cmd_opcode_in == OP_WRITE_ENABLE) |-> ##2 !write_enable_latch_out)
		else $error("latch not cleared after completion");
	power_down_a: assert property (other_ended ##1 deep_power_down_out |-> none)
		else $error("write started in deep power-down");
	status_pin_a: assert property (!write_protect_pin_n_in [*3] ##0 (cmd_end_in &&
		cmd_opcode_in == OP_WRITE_STATUS && {status_protect_mode_hi_in,
		status_protect_mode_lo_in} == SPM_HARDWARE) |=> cmd_rejected_out)
		else $error("status write taken with pin low");
	dummy_map_a: assert property (!$past(sys_rst_in) && !$past(sys_rst_in, 2) |->
		dummy_cycles_out == ($past(read_opcode_in) == OP_QUAD_IO_READ ?
		($past(dummy_cycle_select_in) ? DUMMY_QUAD_HIGH : DUMMY_QUAD_LOW) :
		($past(dummy_cycle_select_in) ? DUMMY_DUAL_HIGH : DUMMY_DUAL_LOW)))
		else $error("wrong dummy cycle count");
endmodule
bind fwp_core fwp_core_assertions #(.POWERUP_DELAY_CYCLES(POWERUP_DELAY_CYCLES)) chk_i (
	.core_clk_in, .sys_rst_in, .cmd_end_in, .cmd_opcode_in, .cmd_bit_count_in, .op_done_in,
	.write_protect_pin_n_in, .status_protect_mode_hi_in, .status_protect_mode_lo_in,
	.dummy_cycle_select_in, .read_opcode_in, .start_array_op_out, .start_chip_erase_out,
	.start_status_write_out, .cmd_rejected_out, .write_enable_latch_out,
	.deep_power_down_out, .ready_out, .dummy_cycles_out);

// *** sim/fwp_core_bench.sv ***
`timescale 1ns/100ps
module fwp_core_bench
	import fwp_pkg::*;
;
	localparam logic [3:0] A = 4'h8, C = 4'h4, S = 4'h2, R = 4'h1, N = 4'h0;
	logic core_clk_in, sys_rst_in, cmd_end_in, op_done_in, write_protect_pin_n_in;
	logic protect_scheme_select_in, complement_protect_in, top_bottom_select_in;
	logic granularity_select_in, dummy_cycle_select_in;
	logic block_protect_level_hi_in, block_protect_level_mid_in, block_protect_level_lo_in;
	logic status_protect_mode_hi_in, status_protect_mode_lo_in;
	logic [7:0] cmd_opcode_in, read_opcode_in;
	logic [23:0] cmd_addr_in;
	logic [5:0] cmd_bit_count_in;
	logic start_array_op_out, start_chip_erase_out, start_status_write_out, cmd_rejected_out;
	logic write_enable_latch_out, deep_power_down_out, ready_out;
	logic [3:0] dummy_cycles_out;
	int bad_count = 0, total_checks = 0, cyc = 0;
	fwp_core #(.POWERUP_DELAY_CYCLES(10)) fwp_core_i (.*);
	fwp_host_model fwp_host_model_i (.clk_in(core_clk_in), .cmd_end_out(cmd_end_in),
		.opcode_out(cmd_opcode_in), .addr_out(cmd_addr_in), .bits_out(cmd_bit_count_in));
	initial begin
		core_clk_in = 1'b0;
		forever #2.5 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask
	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic res(input logic [3:0] exp);
		chk("outcome", exp, {start_array_op_out, start_chip_erase_out,
			start_status_write_out, cmd_rejected_out});
	endtask
	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [3:0] exp);
		fwp_host_model_i.send(op, a, 6'h20);
		res(exp);
		tick(1);
	endtask
	// Write enable first, then the command, then a completion to clear the latch.
	task automatic wcmd(input logic [7:0] op, input logic [23:0] a, input logic [3:0] exp);
		cmd(OP_WRITE_ENABLE, 24'h0, N);
		cmd(op, a, exp);
		op_done_in = 1'b1;
		tick(1);
		op_done_in = 1'b0;
	endtask
	task automatic prot(input logic [2:0] f, input logic [2:0] l);
		{granularity_select_in, top_bottom_select_in, complement_protect_in} = f;
		{block_protect_level_hi_in, block_protect_level_mid_in, block_protect_level_lo_in} = l;
		tick(1);
	endtask
	initial begin
		{sys_rst_in, write_protect_pin_n_in} = 2'b11;
		{op_done_in, protect_scheme_select_in, dummy_cycle_select_in} = 3'b000;
		{status_protect_mode_hi_in, status_protect_mode_lo_in} = 2'b00;
		read_opcode_in = OP_DUAL_IO_READ;
		prot(3'b000, 3'd0);
		tick(4);
		cmd(OP_WRITE_ENABLE, 24'h0, N);
		sys_rst_in = 1'b0;
		cmd(OP_WRITE_ENABLE, 24'h0, R);
		for (int i = 0; i < 40 && ready_out !== 1'b1; i++)
			tick(1);
		chk("ready", 4'h1, {3'h0, ready_out});
		chk("latch", 4'h0, {3'h0, write_enable_latch_out});
		$display("test power-up done");
		cmd(OP_BLOCK_ERASE, 24'h100000, R);
		cmd(OP_WRITE_ENABLE, 24'h0, N);
		chk("latch", 4'h1, {3'h0, write_enable_latch_out});
		fwp_host_model_i.send(OP_BLOCK_ERASE, 24'h100000, 6'h1B);
		res(R);
		tick(1);
		cmd(OP_BLOCK_ERASE, 24'h100000, A);
		op_done_in = 1'b1;
		tick(1);
		op_done_in = 1'b0;
		tick(1);
		chk("latch", 4'h0, {3'h0, write_enable_latch_out});
		wcmd(OP_CHIP_ERASE, 24'h0, C);
		wcmd(OP_WRITE_STATUS, 24'h0, S);
		$display("test latch done");
		prot(3'b000, 3'd1);
		wcmd(OP_BLOCK_ERASE, 24'hFC0000, R);
		wcmd(OP_BLOCK_ERASE, 24'hFB0000, A);
		wcmd(OP_CHIP_ERASE, 24'h0, R);
		prot(3'b010, 3'd1);
		wcmd(OP_BLOCK_ERASE, 24'h030000, R);
		wcmd(OP_BLOCK_ERASE, 24'h040000, A);
		prot(3'b000, 3'd7);
		wcmd(OP_SECTOR_ERASE, 24'h000000, R);
		prot(3'b000, 3'd6);
		wcmd(OP_PAGE_PROGRAM, 24'h7FFF00, A);
		wcmd(OP_PAGE_PROGRAM, 24'h800000, R);
		prot(3'b100, 3'd1);
		wcmd(OP_BLOCK_ERASE, 24'hFF0000, R);
		wcmd(OP_SECTOR_ERASE, 24'hFFE000, A);
		prot(3'b110, 3'd5);
		wcmd(OP_SECTOR_ERASE, 24'h007000, R);
		wcmd(OP_SECTOR_ERASE, 24'h008000, A);
		prot(3'b001, 3'd1);
		wcmd(OP_BLOCK_ERASE, 24'h000000, R);
		wcmd(OP_BLOCK_ERASE, 24'hFC0000, A);
		prot(3'b001, 3'd0);
		wcmd(OP_SECTOR_ERASE, 24'h800000, R);
		prot(3'b000, 3'd0);
		$display("test ranges done");
		protect_scheme_select_in = 1'b1;
		wcmd(OP_BLOCK_ERASE, 24'h100000, R);
		wcmd(OP_INDIV_UNLOCK, 24'h100000, N);
		wcmd(OP_BLOCK_ERASE, 24'h100000, A);
		wcmd(OP_BLOCK_ERASE, 24'h110000, R);
		wcmd(OP_INDIV_UNLOCK, 24'hFFF000, N);
		wcmd(OP_SECTOR_ERASE, 24'hFFF000, A);
		wcmd(OP_SECTOR_ERASE, 24'hFFE000, R);
		protect_scheme_select_in = 1'b0;
		wcmd(OP_BLOCK_ERASE, 24'h110000, A);
		$display("test locks done");
		{status_protect_mode_hi_in, status_protect_mode_lo_in, write_protect_pin_n_in} = 3'b010;
		tick(3);
		wcmd(OP_WRITE_STATUS, 24'h0, R);
		write_protect_pin_n_in = 1'b1;
		tick(3);
		wcmd(OP_WRITE_STATUS, 24'h0, S);
		status_protect_mode_lo_in = 1'b0;
		cmd(OP_DEEP_POWER_DOWN, 24'h0, N);
		cmd(OP_WRITE_ENABLE, 24'h0, R);
		chk("power down", 4'h1, {3'h0, deep_power_down_out});
		cmd(OP_BLOCK_ERASE, 24'h100000, R);
		cmd(OP_RELEASE_PD, 24'h0, N);
		wcmd(OP_BLOCK_ERASE, 24'h100000, A);
		$display("test status and power down done");
		for (int i = 0; i < 4; i++) begin
			read_opcode_in = i[1] ? OP_QUAD_IO_READ : OP_DUAL_IO_READ;
			dummy_cycle_select_in = i[0];
			tick(2);
			chk("dummy", i[1] ? (i[0] ? DUMMY_QUAD_HIGH : DUMMY_QUAD_LOW) :
				(i[0] ? DUMMY_DUAL_HIGH : DUMMY_DUAL_LOW), dummy_cycles_out);
		end
		$display("test dummy done");
		summarize();
	end
endmodule

// *** sim/fwp_host_model.sv ***
`timescale 1ns/100ps
// Host side. Between commands the lines show the inverse of the last value,
// because nothing holds them once a frame has closed.
module fwp_host_model
	import fwp_pkg::*;
(
	// Clock
	input  wire logic              clk_in,
	// Command end report
	output logic                   cmd_end_out,
	output logic [7:0]             opcode_out,
	output logic [ADDR_W-1:0]      addr_out,
	output logic [5:0]             bits_out
);
	initial begin
		cmd_end_out = 1'b0;
		opcode_out = 8'h00;
		addr_out = '0;
		bits_out = 6'h00;
	end
	// Called just after a rising edge; the command is taken at the next one.
	task automatic send(input logic [7:0] op, input logic [ADDR_W-1:0] a, input logic [5:0] b);
		cmd_end_out = 1'b1;
		opcode_out = op;
		addr_out = a;
		bits_out = b;
		@(posedge clk_in);
		#1;
		cmd_end_out = 1'b0;
		opcode_out = ~op;
		addr_out = ~a;
		bits_out = ~b;
	endtask
endmodule

// *** verilog/fwp_core.sv ***
`timescale 1ns/100ps
// Summary of operation
// - Dual-IO read dummy cycles: 4, or 8.
// - Quad-IO read dummy cycles: 6, or 10.
// - Write commands need whole-byte length.
// - No commands during power-on reset.
// - Reject commands for power-up delay.
// - Power-up clears write enable latch.
// - Writes need write enable latch set.
// - Completed write operation clears latch.
// - Deep power-down accepts only release.
// - 254 block locks plus 32 sector locks.
// - Locked units reject program and erase.
// - Power-on sets every lock bit.
// - Unlock command clears addressed lock bit.
// - Scheme select picks range or locks.
// - Block-level range map, top or bottom.
// - Sector-level range map, 4 to 32 KB.
// - Any overlap with protection blocks command.
// - Hardware mode with pin low blocks status.
// - Granularity select: sectors or blocks.
module fwp_core
	import fwp_pkg::*;
#(
	parameter int POWERUP_DELAY_CYCLES = POWERUP_CYCLES
)
(
	// Clock and reset
	input  wire logic              core_clk_in,
	input  wire logic              sys_rst_in,
	// Decoded command from the serial front end, sampled at chip-select rise
	input  wire logic              cmd_end_in,
	input  wire logic [7:0]        cmd_opcode_in,
	input  wire logic [ADDR_W-1:0] cmd_addr_in,
	input  wire logic [5:0]        cmd_bit_count_in,
	// Completion of an internal program, erase or status-write cycle
	input  wire logic              op_done_in,
	// Write-protect pin, asynchronous
	input  wire logic              write_protect_pin_n_in,
	// Protection configuration from the status registers
	input  wire logic              protect_scheme_select_in,
	input  wire logic              complement_protect_in,
	input  wire logic              top_bottom_select_in,
	input  wire logic              granularity_select_in,
	input  wire logic              block_protect_level_hi_in,
	input  wire logic              block_protect_level_mid_in,
	input  wire logic              block_protect_level_lo_in,
	input  wire logic              status_protect_mode_hi_in,
	input  wire logic              status_protect_mode_lo_in,
	input  wire logic              dummy_cycle_select_in,
	// Read command whose latency is wanted
	input  wire logic [7:0]        read_opcode_in,
	// Decision outputs
	output logic                   start_array_op_out,
	output logic                   start_chip_erase_out,
	output logic                   start_status_write_out,
	output logic                   cmd_rejected_out,
	output logic                   write_enable_latch_out,
	output logic                   deep_power_down_out,
	output logic                   ready_out,
	output logic [3:0]             dummy_cycles_out
);

	logic                  wp_meta_reg;
	logic                  wp_sync_reg;
	logic [PU_CNT_W-1:0]   pu_cnt_reg;
	logic                  ready_reg;
	logic                  wel_reg;
	logic                  dpd_reg;
	logic [NUM_LOCKS-1:0]  lock_reg;
	fwp_cls_e              cls;
	logic [ADDR_W-1:0]     span_end;
	logic                  byte_aligned;
	logic                  range_hit;
	logic [LOCK_IDX_W-1:0] lock_idx;
	logic                  lock_hit;
	logic [NUM_LOCKS-1:0]  lock_in_span;
	logic [ADDR_W-1:0]     range_start;
	logic [ADDR_W-1:0]     range_end;
	logic                  array_protected;
	logic                  status_locked;
	logic                  accept;
	logic [2:0]            level;

	assign level = {block_protect_level_hi_in, block_protect_level_mid_in,
		block_protect_level_lo_in};

	// The pin crosses in from outside, so it is synchronised before use.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			wp_meta_reg <= 1'b0;
			wp_sync_reg <= 1'b0;
		end else begin
			wp_meta_reg <= write_protect_pin_n_in;
			wp_sync_reg <= wp_meta_reg;
		end
	end

	// Power-up lockout: reset holds everything off, then a fixed delay runs out.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			pu_cnt_reg <= '0;
			ready_reg  <= 1'b0;
		end else if (!ready_reg) begin
			// The count stops once ready is set, so it cannot wrap and drop ready again.
			if (pu_cnt_reg == PU_CNT_W'(POWERUP_DELAY_CYCLES - 1))
				ready_reg <= 1'b1;
			else
				pu_cnt_reg <= pu_cnt_reg + 1'b1;
		end
	end

	// Command classification.
	always_comb begin
		cls      = FWP_CLS_OTHER;
		span_end = cmd_addr_in;
		case (cmd_opcode_in)
			OP_PAGE_PROGRAM, OP_QUAD_PROGRAM: begin
				cls = FWP_CLS_ARRAY;
				span_end = {cmd_addr_in[ADDR_W-1:8], 8'hFF};
			end
			OP_SECTOR_ERASE: begin
				cls = FWP_CLS_ARRAY;
				span_end = {cmd_addr_in[ADDR_W-1:SECTOR_LSB], 12'hFFF};
			end
			OP_BLOCK_ERASE_32K: begin
				cls = FWP_CLS_ARRAY;
				span_end = {cmd_addr_in[ADDR_W-1:15], 15'h7FFF};
			end
			OP_BLOCK_ERASE: begin
				cls = FWP_CLS_ARRAY;
				span_end = {cmd_addr_in[ADDR_W-1:BLOCK_LSB], 16'hFFFF};
			end
			OP_CHIP_ERASE, OP_CHIP_ERASE_ALT: begin
				cls = FWP_CLS_CHIP;
			end
			OP_WRITE_STATUS, OP_WRITE_STATUS2: begin
				cls = FWP_CLS_STATUS;
			end
			OP_INDIV_UNLOCK, OP_INDIV_LOCK, OP_GLOBAL_LOCK, OP_GLOBAL_UNLOCK: begin
				cls = FWP_CLS_LOCK;
			end
			default: begin
				cls = FWP_CLS_OTHER;
			end
		endcase
	end

	// Span of the command as the protection checks see it; chip erase covers the array.
	always_comb begin
		if (cls == FWP_CLS_CHIP) begin
			range_start = '0;
			range_end   = '1;
		end else begin
			range_start = cmd_addr_in;
			range_end   = span_end;
		end
	end

	// Page program wraps within its page, but the span checked runs from the address to the page end.
	fwp_range_decode u_range (
		.level_in              (level),
		.top_bottom_select_in  (top_bottom_select_in),
		.granularity_select_in (granularity_select_in),
		.complement_protect_in (complement_protect_in),
		.start_addr_in         (range_start),
		.end_addr_in           (range_end),
		.hit_out               (range_hit)
	);

	// Map an address to its lock bit: sectors at the ends, blocks between.
	always_comb begin
		if (cmd_addr_in[ADDR_W-1:BLOCK_LSB] == BOTTOM_BLOCK)
			lock_idx = BOTTOM_SECTOR_BASE + 10'(cmd_addr_in[15:12]);
		else if (cmd_addr_in[ADDR_W-1:BLOCK_LSB] == TOP_BLOCK)
			lock_idx = TOP_SECTOR_BASE + 10'(cmd_addr_in[15:12]);
		else
			lock_idx = MID_BLOCK_BASE + 10'(cmd_addr_in[ADDR_W-1:BLOCK_LSB]);
	end

	// One span flag per lock bit. Each lock owns a fixed address unit, so the flag is a
	// plain overlap test against constants. The index gap between the last middle block
	// and the top sectors holds no unit; those bits never count, otherwise their reset
	// value of 1 would block every chip erase under the lock scheme for good.
	for (genvar i = 0; i < NUM_LOCKS; i++) begin : g_span
		localparam bit IS_BOTTOM = (i <= int'(MID_BLOCK_BASE));
		localparam bit IS_TOP    = (i >= int'(TOP_SECTOR_BASE));
		localparam bit IS_USED   = IS_BOTTOM || IS_TOP
			|| (i < int'(MID_BLOCK_BASE) + int'(TOP_BLOCK));
		localparam int UNIT_LO   = IS_BOTTOM ? (i << SECTOR_LSB)
			: IS_TOP ? ((int'(TOP_BLOCK) << BLOCK_LSB)
			+ ((i - int'(TOP_SECTOR_BASE)) << SECTOR_LSB))
			: ((i - int'(MID_BLOCK_BASE)) << BLOCK_LSB);
		localparam int UNIT_HI   = UNIT_LO + ((IS_BOTTOM || IS_TOP) ? (1 << SECTOR_LSB)
			: (1 << BLOCK_LSB)) - 1;
		always_comb begin
			lock_in_span[i] = 1'b0;
			if (IS_USED) begin
				if (32'(range_end) >= 32'(UNIT_LO) && 32'(range_start) <= 32'(UNIT_HI))
					lock_in_span[i] = 1'b1;
			end
		end
	end

	// Any set lock inside the span blocks the whole command.
	assign lock_hit = |(lock_reg & lock_in_span);

	assign array_protected = protect_scheme_select_in ? lock_hit : range_hit;
	assign status_locked   = status_protect_mode_hi_in
		|| ({status_protect_mode_hi_in, status_protect_mode_lo_in} == SPM_HARDWARE
		&& !wp_sync_reg);
	assign byte_aligned    = (cmd_bit_count_in[2:0] == 3'h0);

	// Acceptance of one completed command.
	always_comb begin
		accept = 1'b0;
		case (cls)
			FWP_CLS_ARRAY, FWP_CLS_CHIP: begin
				accept = wel_reg && byte_aligned && !array_protected;
			end
			FWP_CLS_STATUS: begin
				accept = wel_reg && byte_aligned && !status_locked;
			end
			FWP_CLS_LOCK: begin
				accept = wel_reg && byte_aligned;
			end
			default: begin
				accept = byte_aligned;
			end
		endcase
		if (!ready_reg)
			accept = 1'b0;
		if (dpd_reg && cmd_opcode_in != OP_RELEASE_PD)
			accept = 1'b0;
	end

	// Write enable latch. An accepted write enable in the same cycle as a completion
	// wins, so a host that re-arms early does not lose its enable.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			wel_reg <= 1'b0;
		end else if (cmd_end_in && accept && cmd_opcode_in == OP_WRITE_ENABLE) begin
			wel_reg <= 1'b1;
		end else if (cmd_end_in && accept && cmd_opcode_in == OP_WRITE_DISABLE) begin
			wel_reg <= 1'b0;
		end else if (op_done_in) begin
			wel_reg <= 1'b0;
		end else if (cmd_end_in && accept && cls == FWP_CLS_LOCK) begin
			wel_reg <= 1'b0;
		end
	end

	// Deep power-down state.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			dpd_reg <= 1'b0;
		end else if (cmd_end_in && accept) begin
			if (cmd_opcode_in == OP_DEEP_POWER_DOWN)
				dpd_reg <= 1'b1;
			else if (cmd_opcode_in == OP_RELEASE_PD)
				dpd_reg <= 1'b0;
		end
	end

	// Individual lock array, one generate slice per lock bit.
	for (genvar i = 0; i < NUM_LOCKS; i++) begin : g_lock
		always_ff @(posedge core_clk_in) begin
			if (sys_rst_in) begin
				lock_reg[i] <= 1'b1;
			end else if (cmd_end_in && accept) begin
				if (cmd_opcode_in == OP_GLOBAL_LOCK)
					lock_reg[i] <= 1'b1;
				else if (cmd_opcode_in == OP_GLOBAL_UNLOCK)
					lock_reg[i] <= 1'b0;
				else if (cmd_opcode_in == OP_INDIV_UNLOCK && lock_idx == LOCK_IDX_W'(i))
					lock_reg[i] <= 1'b0;
				else if (cmd_opcode_in == OP_INDIV_LOCK && lock_idx == LOCK_IDX_W'(i))
					lock_reg[i] <= 1'b1;
			end
		end
	end

	// Start strobes, one cycle after the command ends.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			start_array_op_out     <= 1'b0;
			start_chip_erase_out   <= 1'b0;
			start_status_write_out <= 1'b0;
		end else begin
			start_array_op_out     <= cmd_end_in && accept && cls == FWP_CLS_ARRAY;
			start_chip_erase_out   <= cmd_end_in && accept && cls == FWP_CLS_CHIP;
			start_status_write_out <= cmd_end_in && accept && cls == FWP_CLS_STATUS;
		end
	end

	// Reject flag, in the same cycle as a start strobe would have come.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			cmd_rejected_out <= 1'b0;
		end else begin
			cmd_rejected_out <= cmd_end_in && !accept;
		end
	end

	// Read latency selection. The host must pick the longer setting for fast clocks;
	// nothing here checks the clock rate.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			dummy_cycles_out <= DUMMY_DUAL_LOW;
		end else if (read_opcode_in == OP_QUAD_IO_READ) begin
			dummy_cycles_out <= dummy_cycle_select_in ? DUMMY_QUAD_HIGH : DUMMY_QUAD_LOW;
		end else begin
			dummy_cycles_out <= dummy_cycle_select_in ? DUMMY_DUAL_HIGH : DUMMY_DUAL_LOW;
		end
	end

	// Mirrors of internal state.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			write_enable_latch_out <= 1'b0;
			deep_power_down_out    <= 1'b0;
		end else begin
			write_enable_latch_out <= wel_reg;
			deep_power_down_out    <= dpd_reg;
		end
	end

	// Ready mirror; it trails the internal flag, so a host polling it never sends early.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			ready_out <= 1'b0;
		end else begin
			ready_out <= ready_reg;
		end
	end

endmodule

// *** verilog/fwp_pkg.sv ***
package fwp_pkg;

	// Opcodes.
	localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE    = 8'h04;
	localparam logic [7:0] OP_WRITE_STATUS     = 8'h01;
	localparam logic [7:0] OP_WRITE_STATUS2    = 8'h11;
	localparam logic [7:0] OP_PAGE_PROGRAM     = 8'h02;
	localparam logic [7:0] OP_QUAD_PROGRAM     = 8'h32;
	localparam logic [7:0] OP_SECTOR_ERASE     = 8'h20;
	localparam logic [7:0] OP_BLOCK_ERASE_32K  = 8'h52;
	localparam logic [7:0] OP_BLOCK_ERASE      = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE       = 8'hC7;
	localparam logic [7:0] OP_CHIP_ERASE_ALT   = 8'h60;
	localparam logic [7:0] OP_DEEP_POWER_DOWN  = 8'hB9;
	localparam logic [7:0] OP_RELEASE_PD       = 8'hAB;
	localparam logic [7:0] OP_INDIV_UNLOCK     = 8'h39;
	localparam logic [7:0] OP_INDIV_LOCK       = 8'h36;
	localparam logic [7:0] OP_GLOBAL_LOCK      = 8'h7E;
	localparam logic [7:0] OP_GLOBAL_UNLOCK    = 8'h98;
	localparam logic [7:0] OP_DUAL_IO_READ     = 8'hBB;
	localparam logic [7:0] OP_QUAD_IO_READ     = 8'hEB;

	// Dummy cycle counts.
	localparam logic [3:0] DUMMY_DUAL_LOW      = 4'h4;
	localparam logic [3:0] DUMMY_DUAL_HIGH     = 4'h8;
	localparam logic [3:0] DUMMY_QUAD_LOW      = 4'h6;
	localparam logic [3:0] DUMMY_QUAD_HIGH     = 4'hA;

	// Array geometry (24-bit byte address).
	localparam int          ADDR_W             = 24;
	localparam int          BLOCK_LSB          = 16;
	localparam int          SECTOR_LSB         = 12;
	localparam int          NUM_BLOCKS         = 256;
	localparam int          NUM_LOCKS          = 542;
	localparam int          LOCK_IDX_W         = 10;
	localparam logic [7:0]  TOP_BLOCK          = 8'hFF;
	localparam logic [7:0]  BOTTOM_BLOCK       = 8'h00;
	localparam logic [9:0]  BOTTOM_SECTOR_BASE = 10'h000;
	localparam logic [9:0]  MID_BLOCK_BASE     = 10'h00F;
	localparam logic [9:0]  TOP_SECTOR_BASE    = 10'h20E;
	localparam logic [2:0]  LEVEL_NONE         = 3'h0;
	localparam logic [2:0]  LEVEL_ALL          = 3'h7;

	// Status protect mode encodings.
	localparam logic [1:0]  SPM_SOFTWARE       = 2'h0;
	localparam logic [1:0]  SPM_HARDWARE       = 2'h1;

	// Power-up command delay.
	localparam int          CLK_MHZ            = 200;
	localparam int          POWERUP_DELAY_US   = 300;
	localparam int          POWERUP_CYCLES     = POWERUP_DELAY_US * CLK_MHZ;
	localparam int          PU_CNT_W           = 17;

	// Command classes.
	typedef enum logic [2:0] {
		FWP_CLS_OTHER,
		FWP_CLS_ARRAY,
		FWP_CLS_CHIP,
		FWP_CLS_STATUS,
		FWP_CLS_LOCK
	} fwp_cls_e;

endpackage

// *** verilog/fwp_range_decode.sv ***
`timescale 1ns/100ps
// Turns the protect bits into a protected address window [lo, hi] and a hit flag for the query range.
module fwp_range_decode
	import fwp_pkg::*;
(
	// Protect configuration
	input  wire logic [2:0]        level_in,
	input  wire logic              top_bottom_select_in,
	input  wire logic              granularity_select_in,
	input  wire logic              complement_protect_in,
	// Query range
	input  wire logic [ADDR_W-1:0] start_addr_in,
	input  wire logic [ADDR_W-1:0] end_addr_in,
	// Result
	output logic                   hit_out
);

	logic [ADDR_W-1:0] size_m1;
	logic              none_sel;
	logic              all_sel;
	logic [ADDR_W-1:0] lo;
	logic [ADDR_W-1:0] hi;
	logic              overlap;
	logic              covered;

	always_comb begin
		none_sel = (level_in == LEVEL_NONE);
		all_sel  = (level_in == LEVEL_ALL);
		size_m1  = '0;
		if (granularity_select_in) begin
			// Level 10x saturates at 32 KB, same as 110.
			if (level_in[2])
				size_m1 = 24'h007FFF;
			else
				size_m1 = ADDR_W'((24'h000800 << level_in) - 24'h1);
		end else begin
			size_m1 = ADDR_W'((24'h020000 << level_in) - 24'h1);
		end
		if (top_bottom_select_in) begin
			lo = 24'h000000;
			hi = size_m1;
		end else begin
			lo = 24'hFFFFFF - size_m1;
			hi = 24'hFFFFFF;
		end
		if (all_sel) begin
			lo = 24'h000000;
			hi = 24'hFFFFFF;
		end
		overlap = !none_sel && !(end_addr_in < lo || start_addr_in > hi);
		covered = !none_sel && start_addr_in >= lo && end_addr_in <= hi;
		// Inverted map protects everything outside the window, so a command is blocked
		// unless it lies wholly inside the selected window.
		if (complement_protect_in)
			hit_out = !covered;
		else
			hit_out = overlap;
	end

endmodule
